// *** core/reset_and_address_error_unit.v ***
// Purpose: reset kind decision, reset vector fetch and address error detection
// Assumes: all inputs synchronous to clk; vector reads use a simple req/ack pair
// Notes: bus cycle and instruction status come from the cpu core
`include "reset_addr_err_map.vh"
`default_nettype none

// Behaviour
// RL1: reset overrides every other exception source
// RL2: init pin low, nmi high: power-on reset
// RL3: power-on initializes cpu and all peripherals
// RL4: init pin low, nmi low: manual reset
// RL5: manual reset spares bus, break, pin, frequency
// RL6: board holds power-on reset long enough
// RL7: board holds manual reset twenty clocks
// RL8: power-on handling starts on release, nmi high
// RL9: fetch pc then sp, load, start
// RL10: vector base cleared, interrupt mask all ones
// RL11: manual reset waits for bus cycle end
// RL12: manual release runs same fetch sequence
// RL13: odd instruction fetch raises address error
// RL14: fetch from peripheral space raises error
// RL15: odd word data access raises error
// RL16: misaligned longword access raises error
// RL17: pc-relative access to special spaces errors
// RL18: test-and-set to special spaces errors
// RL19: low peripheral window accepts every size
// RL20: longword in mid peripheral window errors
// RL21: byte in two peripheral windows errors
// RL22: error handling after cycle and instruction end
// RL23: both dma units share one vector
// RL24: cpu and dma errors flagged separately
module reset_and_address_error_unit
#(
  parameter CACHE_PURGE_LO = 32'h40000000,
  parameter CACHE_PURGE_HI = 32'h5fffffff,
  parameter ADDR_ARRAY_LO = 32'h60000000,
  parameter ADDR_ARRAY_HI = 32'h7fffffff,
  parameter DATA_ARRAY_LO = 32'hc0000000,
  parameter DATA_ARRAY_HI = 32'hc0000fff,
  parameter SDRAM_MODE_LO = 32'hffff8000,
  parameter SDRAM_MODE_HI = 32'hffffbfff
)
(
  input wire clk,
  input wire reset,
  input wire externalInitN,
  input wire nmiPin,
  input wire busCycleActive,
  input wire instrDone,
  output reg vecReq,
  output reg [31:0] vecAddr,
  input wire vecAck,
  input wire [31:0] vecData,
  output reg coreInit,
  output reg periphInit,
  output reg preservedInit,
  output reg resetActive,
  output reg powerOnKind,
  output reg pcLoad,
  output reg [31:0] pcValue,
  output reg [31:0] spValue,
  output reg [31:0] vectorBase,
  output reg [3:0] interruptMaskLevel,
  input wire accValid,
  input wire [1:0] accMaster,
  input wire accFetch,
  input wire [1:0] accSize,
  input wire [31:0] accAddr,
  input wire accPcRel,
  input wire accTas,
  output wire accError,
  output reg cpuAePending,
  output reg dmaAePending,
  output reg dmaAeFromDma,
  output reg dmaAeFromEth,
  output reg cpuAeTake,
  output reg dmaAeTake,
  output reg [7:0] aeVectorNum
);

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  // inclusive window compare, used for every space check
  function inWin;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      inWin = (a >= lo) && (a <= hi);
    end
  endfunction

  wire inPeri = inWin(accAddr, `PERI_LO, `PERI_HI);
  wire inPurge = inWin(accAddr, CACHE_PURGE_LO, CACHE_PURGE_HI);
  wire inAddrArr = inWin(accAddr, ADDR_ARRAY_LO, ADDR_ARRAY_HI);
  wire inDataArr = inWin(accAddr, DATA_ARRAY_LO, DATA_ARRAY_HI);
  wire inSdramMode = inWin(accAddr, SDRAM_MODE_LO, SDRAM_MODE_HI);
  wire inAnySize = inWin(accAddr, `PERI_ANY_LO, `PERI_ANY_HI);
  wire inNoLong = inWin(accAddr, `PERI_NOLONG_LO, `PERI_NOLONG_HI);
  wire inNoByte = inWin(accAddr, `PERI_NOBYTE_A_LO, `PERI_NOBYTE_A_HI) |
                  inWin(accAddr, `PERI_NOBYTE_B_LO, `PERI_NOBYTE_B_HI);

  // ----------------------------------------------------------------
  // address error classification
  // ----------------------------------------------------------------
  wire isCpu = (accMaster == `MASTER_CPU);
  wire isDma = (accMaster == `MASTER_DMA);
  wire isEth = (accMaster == `MASTER_EDMA);
  wire isByte = (accSize == `SIZE_BYTE);
  wire isWord = (accSize == `SIZE_WORD);
  wire isLong = (accSize == `SIZE_LONG);

  reg fetchErr;
  reg dataErr;
  reg running;

  // fetch and data faults are mutually exclusive by cycle type
  always @*
  begin
    fetchErr = 1'b0;
    dataErr = 1'b0;
    if (accFetch)
    begin
      if (isCpu && accAddr[0])
        fetchErr = 1'b1; // [RL13]
      if (isCpu && inPeri)
        fetchErr = 1'b1; // [RL14]
    end
    else
    begin
      if (isWord && accAddr[0])
        dataErr = 1'b1; // [RL15]
      if (isLong && (accAddr[1:0] != 2'h0))
        dataErr = 1'b1; // [RL16]
      if (accPcRel && (inPurge || inAddrArr || inPeri || inSdramMode))
        dataErr = 1'b1; // [RL17]
      if (accTas && (inPurge || inAddrArr || inDataArr || inPeri || inSdramMode))
        dataErr = 1'b1; // [RL18]
      // the low window takes any size, so size checks skip it
      if (!inAnySize)
      begin
        if (isLong && inNoLong)
          dataErr = 1'b1; // [RL20]
        if (isByte && inNoByte)
          dataErr = 1'b1; // [RL21]
      end // [RL19]
    end
  end

  // no errors are raised while the reset sequencer owns the core
  assign accError = accValid && running && (fetchErr || dataErr); // [RL1]

  wire cpuErrEvt = accError && isCpu; // [RL24]
  wire dmaErrEvt = accError && (isDma || isEth); // [RL24]

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  // sequencer state codes, plain binary
  localparam [2:0] ST_RUN = 3'b000, ST_POR_HOLD = 3'b001, ST_MR_WAIT = 3'b010,
    ST_MR_HOLD = 3'b011, ST_FETCH_PC = 3'b100, ST_FETCH_SP = 3'b101, ST_LOAD = 3'b110;
  reg [2:0] state;
  reg [2:0] next_state;
  reg porClean;
  wire initLow = !externalInitN;

  // next state; a low init pin wins from every state except ST_MR_WAIT, which waits for the bus cycle end
  always @*
  begin
    next_state = state;
    case (state)
      ST_RUN:
      begin
        if (initLow && nmiPin)
          next_state = ST_POR_HOLD; // [RL2]
        else if (initLow && busCycleActive)
          next_state = ST_MR_WAIT; // [RL11]
        else if (initLow)
          next_state = ST_MR_HOLD; // [RL4]
      end
      ST_MR_WAIT:
      begin
        // the running bus cycle is never cut short
        if (!busCycleActive)
          next_state = ST_MR_HOLD; // [RL11]
      end
      ST_POR_HOLD, ST_MR_HOLD:
      begin
        if (!initLow)
          next_state = ST_FETCH_PC; // [RL8] [RL12]
        else
          next_state = nmiPin ? ST_POR_HOLD : ST_MR_HOLD;
      end
      ST_FETCH_PC:
      begin
        if (initLow)
          next_state = nmiPin ? ST_POR_HOLD : ST_MR_HOLD;
        else if (vecAck)
          next_state = ST_FETCH_SP; // [RL9]
      end
      ST_FETCH_SP:
      begin
        if (initLow)
          next_state = nmiPin ? ST_POR_HOLD : ST_MR_HOLD;
        else if (vecAck)
          next_state = ST_LOAD; // [RL9]
      end
      ST_LOAD:
      begin
        if (initLow)
          next_state = nmiPin ? ST_POR_HOLD : ST_MR_HOLD;
        else
          next_state = ST_RUN;
      end
      default:
        next_state = ST_POR_HOLD;
    endcase
  end

  // state register; local reset behaves as a held power-on reset
  always @(posedge clk)
  begin
    if (reset)
      state <= ST_POR_HOLD;
    else
      state <= next_state;
  end

  // preserved units get init only if nmi stayed high for the whole hold
  always @(posedge clk)
  begin
    if (reset)
      porClean <= 1'b1;
    else if (state == ST_RUN || state == ST_LOAD)
      porClean <= 1'b1;
    else if ((state == ST_POR_HOLD || state == ST_MR_HOLD) && !nmiPin)
      porClean <= 1'b0; // [RL8]
  end

  // ----------------------------------------------------------------
  // init strobes toward cpu and peripherals
  // ----------------------------------------------------------------
  wire holdNext = (next_state == ST_POR_HOLD) || (next_state == ST_MR_HOLD);

  // preserved units see only power-on holds; a late nmi drop keeps them
  always @(posedge clk)
  begin
    if (reset)
    begin
      coreInit <= 1'b1;
      periphInit <= 1'b1;
      preservedInit <= 1'b1;
      resetActive <= 1'b1;
      powerOnKind <= 1'b1;
      running <= 1'b0;
    end
    else
    begin
      coreInit <= holdNext; // [RL3] [RL5]
      periphInit <= holdNext; // [RL3] [RL5]
      preservedInit <= (next_state == ST_POR_HOLD) && porClean && nmiPin; // [RL3] [RL5]
      resetActive <= (next_state != ST_RUN); // [RL1]
      powerOnKind <= (next_state == ST_POR_HOLD) ? 1'b1 :
                     (next_state == ST_MR_HOLD) ? 1'b0 : powerOnKind;
      running <= (next_state == ST_RUN);
    end
  end

  // ----------------------------------------------------------------
  // vector fetch and register load
  // ----------------------------------------------------------------
  reg [31:0] pcFetched;

  // request is raised in the fetch states, address chosen per word
  always @(posedge clk)
  begin
    if (reset)
    begin
      vecReq <= 1'b0;
      vecAddr <= `VEC_OFF_PC;
      pcFetched <= 32'h00000000;
    end
    else
    begin
      vecReq <= (next_state == ST_FETCH_PC) || (next_state == ST_FETCH_SP);
      vecAddr <= (next_state == ST_FETCH_SP) ? `VEC_OFF_SP : `VEC_OFF_PC; // [RL9]
      if (state == ST_FETCH_PC && vecAck && vecReq)
        pcFetched <= vecData; // [RL9]
    end
  end

  // vector base and mask are forced during every hold
  always @(posedge clk)
  begin
    if (reset)
    begin
      pcLoad <= 1'b0;
      pcValue <= 32'h00000000;
      spValue <= 32'h00000000;
      vectorBase <= `VBR_RESET;
      interruptMaskLevel <= `MASK_RESET;
    end
    else
    begin
      pcLoad <= (state == ST_LOAD) && !initLow; // [RL9]
      if (state == ST_FETCH_SP && vecAck && vecReq)
        spValue <= vecData; // [RL9]
      if (state == ST_LOAD)
        pcValue <= pcFetched; // [RL9]
      if (holdNext || state == ST_LOAD)
      begin
        vectorBase <= `VBR_RESET; // [RL10]
        interruptMaskLevel <= `MASK_RESET; // [RL10]
      end
    end
  end

  // ----------------------------------------------------------------
  // address error pending flags and exception launch
  // ----------------------------------------------------------------
  // launch only once the faulting cycle and instruction are over
  wire launchOk = running && !busCycleActive && instrDone; // [RL22]
  wire takeCpu = launchOk && cpuAePending;
  wire takeDma = launchOk && dmaAePending && !cpuAePending;

  // a new error in the launch cycle keeps its flag set
  always @(posedge clk)
  begin
    if (reset || !running)
    begin
      cpuAePending <= 1'b0; // [RL1]
      dmaAePending <= 1'b0;
      dmaAeFromDma <= 1'b0;
      dmaAeFromEth <= 1'b0;
    end
    else
    begin
      cpuAePending <= cpuErrEvt | (cpuAePending & !takeCpu); // [RL24]
      dmaAePending <= dmaErrEvt | (dmaAePending & !takeDma); // [RL24]
      // source bits tell the two dma units apart until the dma launch clears them
      dmaAeFromDma <= (accError && isDma) | (dmaAeFromDma & !takeDma);
      dmaAeFromEth <= (accError && isEth) | (dmaAeFromEth & !takeDma);
    end
  end

  // one launch per cycle, cpu first; dma units share a vector
  always @(posedge clk)
  begin
    if (reset)
    begin
      cpuAeTake <= 1'b0;
      dmaAeTake <= 1'b0;
      aeVectorNum <= 8'h00;
    end
    else
    begin
      cpuAeTake <= takeCpu; // [RL22]
      dmaAeTake <= takeDma; // [RL22]
      if (takeCpu)
        aeVectorNum <= `VECNUM_CPU_AE; // [RL24]
      else if (takeDma)
        aeVectorNum <= `VECNUM_DMA_AE; // [RL23]
    end
  end

endmodule

`default_nettype wire

// *** core/reset_addr_err_map.vh ***
// Purpose: named constants for the reset and address error unit
// Assumes: 32-bit byte addresses, 2-bit size and master codes
// Notes: definitions only, no logic
`ifndef RESET_ADDR_ERR_MAP_VH
`define RESET_ADDR_ERR_MAP_VH

// ----------------------------------------------------------------
// access size and bus master codes
// ----------------------------------------------------------------
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2
`define MASTER_CPU 2'h0
`define MASTER_DMA 2'h1
`define MASTER_EDMA 2'h2

// ----------------------------------------------------------------
// on-chip peripheral module space and its sub-regions
// ----------------------------------------------------------------
`define PERI_LO 32'hffff0000
`define PERI_HI 32'hffffffff
`define PERI_ANY_LO 32'hfffffc00
`define PERI_ANY_HI 32'hfffffcff
`define PERI_NOLONG_LO 32'hfffffe00
`define PERI_NOLONG_HI 32'hfffffeff
`define PERI_NOBYTE_A_LO 32'hffff0000
`define PERI_NOBYTE_A_HI 32'hfffff0ff
`define PERI_NOBYTE_B_LO 32'hffffff00
`define PERI_NOBYTE_B_HI 32'hffffffff

// ----------------------------------------------------------------
// reset fetch and initial values
// ----------------------------------------------------------------
`define VEC_OFF_PC 32'h00000000
`define VEC_OFF_SP 32'h00000004
`define VBR_RESET 32'h00000000
`define MASK_RESET 4'hf
`define VECNUM_CPU_AE 8'h09
`define VECNUM_DMA_AE 8'h0a

`endif

// *** bench/reset_addr_err_checker.sv ***
// Purpose: port-level checks on the reset and address error unit
// Assumes: one clock, reset synchronous and active high
// Notes: bound to every instance of the unit at the foot of this file
`default_nettype none
module reset_addr_err_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic externalInitN,
  input wire logic nmiPin,
  input wire logic busCycleActive,
  input wire logic instrDone,
  input wire logic vecReq,
  input wire logic [31:0] vecAddr,
  input wire logic vecAck,
  input wire logic coreInit,
  input wire logic preservedInit,
  input wire logic resetActive,
  input wire logic pcLoad,
  input wire logic [31:0] vectorBase,
  input wire logic [3:0] interruptMaskLevel,
  input wire logic accValid,
  input wire logic [1:0] accMaster,
  input wire logic accFetch,
  input wire logic [31:0] accAddr,
  input wire logic accError,
  input wire logic cpuAeTake,
  input wire logic dmaAeTake,
  input wire logic [7:0] aeVectorNum
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_POR_ENTRY: assert property
    (!resetActive && !externalInitN && nmiPin |-> ##[1:2] coreInit && preservedInit)
    else $error("power-on hold not entered");
  AST_MR_ENTRY: assert property
    (!resetActive && !externalInitN && !nmiPin && !busCycleActive
      |-> ##[1:2] coreInit && !preservedInit)
    else $error("manual hold not entered");
  AST_FETCH_PC: assert property ($fell(coreInit) |-> vecReq && vecAddr == 32'h0)
    else $error("pc fetch not started on release");
  AST_LOAD: assert property
    (vecReq && vecAck && vecAddr == 32'h4 && externalInitN ##1 externalInitN
      |=> pcLoad && !resetActive && vectorBase == 32'h0 && interruptMaskLevel == 4'hf)
    else $error("load after sp fetch wrong");
  AST_NO_ERR_IN_RESET: assert property (resetActive |-> !accError)
    else $error("access error during reset");
  AST_ODD_FETCH: assert property
    (!resetActive && accValid && accMaster == 2'h0 && accFetch && accAddr[0] |-> accError)
    else $error("odd fetch not flagged");
  AST_CPU_TAKE: assert property
    (cpuAeTake |-> aeVectorNum == 8'h09 && $past(instrDone) && !$past(busCycleActive))
    else $error("cpu error launch wrong");
  AST_DMA_VEC: assert property (dmaAeTake |-> aeVectorNum == 8'h0a && !cpuAeTake)
    else $error("dma error launch wrong");
  // main scenarios reached
  cover property (pcLoad);
  cover property (cpuAeTake);
  cover property (dmaAeTake);
  cover property (coreInit && !preservedInit);
endmodule
bind reset_and_address_error_unit reset_addr_err_checker u_chk (.clk, .reset, .externalInitN,
  .nmiPin, .busCycleActive, .instrDone, .vecReq, .vecAddr, .vecAck, .coreInit, .preservedInit,
  .resetActive, .pcLoad, .vectorBase, .interruptMaskLevel, .accValid, .accMaster, .accFetch,
  .accAddr, .accError, .cpuAeTake, .dmaAeTake, .aeVectorNum);
`default_nettype wire

// *** bench/board_model.sv ***
// Purpose: board side: init and nmi pin drivers plus the vector memory
// Assumes: everything changes just after a rising clock edge
// Notes: delay sets prompt or slow vector answers
`default_nettype none
module board_model #(
  parameter logic [31:0] PC_WORD = 32'h00001000,
  parameter logic [31:0] SP_WORD = 32'h0000f000
) (
  input wire logic clk,
  input wire logic vecReq,
  input wire logic [31:0] vecAddr,
  input wire logic [3:0] delay,
  output logic vecAck,
  output logic [31:0] vecData,
  output logic externalInitN,
  output logic nmiPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitCnt;
  // ------------------------------------------------------------
  // vector memory and pins
  // ------------------------------------------------------------
  initial
  begin
    vecAck = 1'b0;
    vecData = 32'h0;
    externalInitN = 1'b1;
    nmiPin = 1'b1;
    waitCnt = 4'h0;
  end
  // idle data toggles so a stale word never looks valid
  always @(posedge clk)
  begin
    if (vecReq && !vecAck && waitCnt >= delay)
    begin
      vecAck <= 1'b1;
      vecData <= (vecAddr == 32'h4) ? SP_WORD : PC_WORD;
      waitCnt <= 4'h0;
    end
    else
    begin
      vecAck <= 1'b0;
      vecData <= ~vecData;
      waitCnt <= (vecReq && !vecAck) ? waitCnt + 4'h1 : 4'h0;
    end
  end
  // nmi stays put through the hold and the release edge
  task automatic holdLow(input logic nmi, input int cycles);
    @(posedge clk);
    nmiPin <= nmi;
    externalInitN <= 1'b0;
    repeat (cycles) @(posedge clk);
    externalInitN <= 1'b1;
    @(posedge clk);
    nmiPin <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** bench/reset_and_address_error_unit_test.sv ***
// Purpose: self-checking bench for the reset and address error unit
// Assumes: board model drives the pins and answers vector reads
// Notes: each scenario task judges its own results
`include "reset_addr_err_map.vh"
`default_nettype none
module reset_and_address_error_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PCW = 32'h00001000;
  localparam logic [31:0] SPW = 32'h0000f000;
  localparam logic [1:0] B = `SIZE_BYTE;
  localparam logic [1:0] W = `SIZE_WORD;
  localparam logic [1:0] L = `SIZE_LONG;
  localparam logic [1:0] C = `MASTER_CPU;
  localparam logic [1:0] D = `MASTER_DMA;
  localparam logic [1:0] E = `MASTER_EDMA;
  logic clk = 1'b0, reset = 1'b1, busCycleActive = 1'b0, instrDone = 1'b1, accValid = 1'b0;
  logic accFetch = 1'b0, accPcRel = 1'b0, accTas = 1'b0;
  logic [1:0] accMaster = 2'h0, accSize = 2'h0;
  logic [31:0] accAddr = 32'h0;
  logic [3:0] delay = 4'h3;
  logic externalInitN, nmiPin, vecReq, vecAck, coreInit, periphInit, preservedInit, resetActive;
  logic powerOnKind, pcLoad, accError, cpuAePending, dmaAePending, dmaAeFromDma, dmaAeFromEth;
  logic cpuAeTake, dmaAeTake;
  logic [31:0] vecAddr, vecData, pcValue, spValue, vectorBase;
  logic [3:0] interruptMaskLevel;
  logic [7:0] aeVectorNum;
  int badCount = 0;
  int nTests = 0;
  // ------------------------------------------------------------
  // harness
  // ------------------------------------------------------------
  reset_and_address_error_unit u_dut (.clk, .reset, .externalInitN, .nmiPin, .busCycleActive,
    .instrDone, .vecReq, .vecAddr, .vecAck, .vecData, .coreInit, .periphInit, .preservedInit,
    .resetActive, .powerOnKind, .pcLoad, .pcValue, .spValue, .vectorBase, .interruptMaskLevel,
    .accValid, .accMaster, .accFetch, .accSize, .accAddr, .accPcRel, .accTas, .accError,
    .cpuAePending, .dmaAePending, .dmaAeFromDma, .dmaAeFromEth, .cpuAeTake, .dmaAeTake,
    .aeVectorNum);
  board_model #(.PC_WORD(PCW), .SP_WORD(SPW)) u_board (.clk, .vecReq, .vecAddr, .delay,
    .vecAck, .vecData, .externalInitN, .nmiPin);
  // 250 MHz
  always #2 clk = ~clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reportAndStop;
    if (badCount == 0 && nTests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // sel 0 load, 1 cpu launch, 2 dma launch; looked at once the edge settles
  task automatic waitPulse(input int sel);
    for (int i = 0; i < 80; i++)
    begin
      @(posedge clk);
      #1;
      if (sel == 0 ? pcLoad : sel == 1 ? cpuAeTake : dmaAeTake)
        return;
    end
    check("pulse wait", 32'h1, 32'h0);
    reportAndStop();
  endtask
  // one access cycle, error flag judged in the same cycle
  task automatic acc(input logic [1:0] m, input logic f, input logic [1:0] s,
    input logic [31:0] a, input logic p, input logic t, input logic exp);
    @(posedge clk);
    accValid <= 1'b1;
    {accMaster, accFetch, accSize, accAddr, accPcRel, accTas} <= {m, f, s, a, p, t};
    #1;
    check("accError", 32'(accError), 32'(exp));
    @(posedge clk);
    accValid <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic tFirstFetch;
    waitPulse(0);
    check("pcValue", pcValue, PCW);
    check("spValue", spValue, SPW);
    check("vectorBase", vectorBase, 32'h0);
    check("mask", 32'(interruptMaskLevel), 32'hf);
    check("powerOnKind", 32'(powerOnKind), 32'h1);
  endtask
  // pin goes low inside a bus cycle; only the manual kind must wait
  task automatic tPinReset(input logic nmi);
    @(posedge clk);
    busCycleActive <= 1'b1;
    delay <= nmi ? 4'h0 : 4'h2;
    fork
      u_board.holdLow(nmi, 20);
      begin
        repeat (4) @(posedge clk);
        #1;
        check("init in bus cycle", 32'(coreInit), 32'(nmi));
        @(posedge clk);
        busCycleActive <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("periphInit", 32'(periphInit), 32'h1);
        check("preservedInit", 32'(preservedInit), 32'(nmi));
      end
    join
    waitPulse(0);
    check("kind", 32'(powerOnKind), 32'(nmi));
    check("pc after pin reset", pcValue, PCW);
  endtask
  // manual reset outside any bus cycle enters its hold at once
  task automatic tManualIdle;
    fork
      u_board.holdLow(1'b0, 20);
      begin
        repeat (3) @(posedge clk);
        #1;
        check("manual coreInit", 32'(coreInit), 32'h1);
        check("manual preservedInit", 32'(preservedInit), 32'h0);
      end
    join
    waitPulse(0);
    check("manual kind", 32'(powerOnKind), 32'h0);
    check("manual resetActive", 32'(resetActive), 32'h0);
  endtask
  task automatic tAccessTable;
    acc(C, '1, W, 32'h00001000, '0, '0, '0);
    acc(C, '1, W, 32'hfffffc00, '0, '0, '1);
    acc(D, '0, W, 32'h00002001, '0, '0, '1);
    acc(D, '0, L, 32'h00002006, '0, '0, '1);
    acc(E, '0, L, 32'h00002004, '0, '0, '0);
    acc(C, '0, L, 32'h40000000, '1, '0, '1);
    acc(C, '0, L, 32'hffff8000, '1, '0, '1);
    acc(C, '0, B, 32'hc0000004, '0, '1, '1);
    acc(C, '0, B, 32'hfffffc03, '0, '0, '0);
    acc(D, '0, L, 32'hfffffe00, '0, '0, '1);
    acc(C, '0, W, 32'hfffffefe, '0, '0, '0);
    acc(C, '0, B, 32'hfffff0ff, '0, '0, '1);
    acc(E, '0, B, 32'hffffff10, '0, '0, '1);
  endtask
  // both errors held back by an open instruction and bus cycle
  task automatic tLaunch;
    @(posedge clk);
    instrDone <= 1'b0;
    busCycleActive <= 1'b1;
    acc(C, '1, W, 32'h00001003, '0, '0, '1);
    acc(E, '0, W, 32'h00002005, '0, '0, '1);
    @(posedge clk);
    instrDone <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("cpu pending", 32'(cpuAePending), 32'h1);
    check("from eth", 32'(dmaAeFromEth), 32'h1);
    check("from dma", 32'(dmaAeFromDma), 32'h0);
    @(posedge clk);
    busCycleActive <= 1'b0;
    waitPulse(1);
    check("cpu vector", 32'(aeVectorNum), 32'h9);
    check("dma pending", 32'(dmaAePending), 32'h1);
    waitPulse(2);
    check("dma vector", 32'(aeVectorNum), 32'ha);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    tFirstFetch();
    tPinReset(1'b1);
    tPinReset(1'b0);
    tManualIdle();
    tAccessTable();
    tLaunch();
    reportAndStop();
  end
endmodule
`default_nettype wire
